// >>> testbench/fifo_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_side_model
  import fifo_flag_pkg::*;
(
  input  wire logic              ref_clk, // system clock
  output var  logic              wr_clk,  // writer clock, still between words
  output var  logic              rd_clk,  // reader clock, still between words
  output var  logic              wr_en_n, // write enable, active low
  output var  logic              rd_en_n, // read enable, active low
  output var  logic [DATA_W-1:0] wr_data  // write data
);
  initial begin
    wr_clk  = 1'b0;
    rd_clk  = 1'b0;
    wr_en_n = 1'b1;
    rd_en_n = 1'b1;
    wr_data = 18'h3FFFF;
  end

  // free toggling with enables off, used while reset is held
  task automatic spin(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      wr_clk = ~wr_clk;
      rd_clk = ~rd_clk;
    end
  endtask : spin

  // one write clock pulse, 2 ref_clk high and 2 low so no edge is missed
  task automatic write_edge(input logic en_n, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    #1;
    wr_en_n = en_n;
    wr_data = d;
    wr_clk  = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    wr_clk = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    wr_en_n = 1'b1;
    wr_data = ~d; // stale data must never look valid after hold
  endtask : write_edge

  // one read clock pulse, same shape as the write pulse
  task automatic read_edge(input logic en_n);
    @(posedge ref_clk);
    #1;
    rd_en_n = en_n;
    rd_clk  = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    rd_clk = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rd_en_n = 1'b1;
  endtask : read_edge
endmodule : fifo_side_model
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fifo_flag_pkg::*;
  logic              ref_clk          = 1'b0;
  logic              rstn             = 1'b0;
  logic              out_en_n         = 1'b1;
  logic              flag_sync_select = 1'b0;
  logic [OFF_W-1:0]  ae_offset        = 16'h0002; // static long before use
  logic [OFF_W-1:0]  af_offset        = 16'h0001;
  wire logic         wr_clk, rd_clk, wr_en_n, rd_en_n;
  wire logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic              rd_data_oe_n;
  fifo_flags_t       flags;
  int                n_errors  = 0;
  int                cmp_count = 0;

  always #12.5 ref_clk = ~ref_clk;

  fifo_side_model fifo_side_model_i (.ref_clk(ref_clk), .wr_clk(wr_clk), .rd_clk(rd_clk),
    .wr_en_n(wr_en_n), .rd_en_n(rd_en_n), .wr_data(wr_data));

  fifo_flag_core fifo_flag_core_i (.ref_clk(ref_clk), .rstn(rstn), .wr_clk(wr_clk),
    .rd_clk(rd_clk), .wr_en_n(wr_en_n), .rd_en_n(rd_en_n), .out_en_n(out_en_n),
    .flag_sync_select(flag_sync_select), .ae_offset(ae_offset), .af_offset(af_offset),
    .wr_data(wr_data), .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n), .flags(flags));

  task automatic check(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // hang guard, well above the fill run
  initial begin
    repeat (80000) @(posedge ref_clk);
    n_errors++;
    close_out();
  end

  initial begin
    fifo_side_model_i.spin(2); // clocks run while reset is held
    rstn = 1'b1;
    // output must stay released on every edge after release while disabled
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      #1;
      check("oe_n", 18'h00001, 18'(rd_data_oe_n));
    end
    check("flags", 18'(FLAGS_RST), 18'(flags));
    check("rd_data", 18'h00000, rd_data);
    out_en_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    check("oe_n", 18'h00000, 18'(rd_data_oe_n));
    // read while empty is dropped
    fifo_side_model_i.read_edge(1'b0);
    check("rd_data", 18'h00000, rd_data);
    fifo_side_model_i.write_edge(1'b0, 18'h2AAAA);
    check("empty", 18'h00000, 18'(flags.empty_flag));
    fifo_side_model_i.read_edge(1'b1);
    check("flags", 18'h0001B, 18'(flags));
    fifo_side_model_i.read_edge(1'b0);
    check("rd_data", 18'h2AAAA, rd_data);
    check("flags", 18'(FLAGS_RST), 18'(flags));
    // almost-empty threshold with n = 2
    for (int i = 0; i < 3; i++) fifo_side_model_i.write_edge(1'b0, 18'(16 + i));
    check("ae", 18'h00000, 18'(flags.almost_empty_flag));
    fifo_side_model_i.read_edge(1'b1);
    check("flags", 18'h0001F, 18'(flags));
    fifo_side_model_i.read_edge(1'b0);
    check("rd_data", 18'h00010, rd_data);
    check("flags", 18'h0001B, 18'(flags));
    // fill from level 2 to full, watching half, almost-full and full
    for (int lvl = 3; lvl <= 8192; lvl++) begin
      fifo_side_model_i.write_edge(1'b0, 18'(lvl));
      check("half", 18'(lvl <= 4096), 18'(flags.half_level_flag));
      check("af", 18'(lvl + 1 < 8192), 18'(flags.almost_full_flag));
      check("full", 18'(lvl < 8192), 18'(flags.full_flag));
    end
    fifo_side_model_i.write_edge(1'b0, 18'h15555); // dropped while full
    fifo_side_model_i.read_edge(1'b0);
    check("rd_data", 18'h00011, rd_data);
    check("full", 18'h00000, 18'(flags.full_flag));
    fifo_side_model_i.write_edge(1'b1, 18'h00000);
    check("full", 18'h00001, 18'(flags.full_flag));
    fifo_side_model_i.write_edge(1'b0, 18'h0ABCD);
    check("full", 18'h00000, 18'(flags.full_flag));
    // free-running almost flags: the ae offset moves almost-empty with no clock edge
    flag_sync_select = 1'b1;
    ae_offset        = 16'h2000;
    af_offset        = 16'h0000;
    repeat (4) @(posedge ref_clk);
    #1;
    check("ae", 18'h00000, 18'(flags.almost_empty_flag));
    ae_offset = 16'h1FFF;
    repeat (4) @(posedge ref_clk);
    #1;
    check("ae", 18'h00001, 18'(flags.almost_empty_flag));
    fifo_side_model_i.read_edge(1'b0);
    check("rd_data", 18'h00012, rd_data);
    check("flags", 18'h0000A, 18'(flags));
    // reset in mid-run with clocks toggling and output enabled
    rstn = 1'b0;
    fifo_side_model_i.spin(2);
    rstn = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check("flags", 18'(FLAGS_RST), 18'(flags));
    check("rd_data", 18'h00000, rd_data);
    check("oe_n", 18'h00000, 18'(rd_data_oe_n));
    fifo_side_model_i.write_edge(1'b0, 18'h01234);
    fifo_side_model_i.read_edge(1'b1);
    fifo_side_model_i.read_edge(1'b0);
    check("rd_data", 18'h01234, rd_data);
    close_out();
  end
endmodule : tb
`default_nettype wire

// >>> verilog/fifo_flag_core.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_flag_core
  import fifo_flag_pkg::*;
(
  input  wire logic              ref_clk,          // system clock, 40 MHz
  input  wire logic              rstn,             // async reset, active low
  input  wire logic              wr_clk,           // writer clock pin
  input  wire logic              rd_clk,           // reader clock pin
  input  wire logic              wr_en_n,          // write enable, active low
  input  wire logic              rd_en_n,          // read enable, active low
  input  wire logic              out_en_n,         // output enable, active low
  input  wire logic              flag_sync_select, // 0 = synchronous almost flags
  input  wire logic [OFF_W-1:0]  ae_offset,        // almost-empty offset n
  input  wire logic [OFF_W-1:0]  af_offset,        // almost-full offset m
  input  wire logic [DATA_W-1:0] wr_data,          // write data
  output logic      [DATA_W-1:0] rd_data,          // read data register
  output logic                   rd_data_oe_n,     // low while rd_data is driven
  output var fifo_flags_t        flags             // all status flags, active low
);
  // two-stage pin synchroniser, stage one feeds only stage two
  fifo_pins_t pins_meta_q, pins_q, pins_d;
  logic wr_clk_prev_q, rd_clk_prev_q;

  always_comb begin
    pins_d = '{wr_clk, rd_clk, wr_en_n, rd_en_n, out_en_n, flag_sync_select,
               ae_offset, af_offset, wr_data};
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      // idle levels, not zero: a zero enable would look active after release
      pins_meta_q   <= PINS_RST;
      pins_q        <= PINS_RST;
      wr_clk_prev_q <= 1'b0;
      rd_clk_prev_q <= 1'b0;
    end else begin
      pins_meta_q   <= pins_d;
      pins_q        <= pins_meta_q;
      wr_clk_prev_q <= pins_q.wr_clk;
      rd_clk_prev_q <= pins_q.rd_clk;
    end
  end

  // edge events; clocks may run in reset since all state is held constant then
  logic wr_ev, rd_ev, wr_go, rd_go, async_mode;
  always_comb begin
    wr_ev      = pins_q.wr_clk & ~wr_clk_prev_q;
    rd_ev      = pins_q.rd_clk & ~rd_clk_prev_q;
    wr_go      = wr_ev & ~pins_q.wr_en_n & flags.full_flag;
    rd_go      = rd_ev & ~pins_q.rd_en_n & flags.empty_flag;
    async_mode = pins_q.flag_sync_select;
  end

  // pointer and flag state
  logic [PTR_W-1:0]  wbin_q, wbin_d, wgray_q, wgray_d;
  logic [PTR_W-1:0]  rbin_q, rbin_d, rgray_q, rgray_d;
  logic [PTR_W-1:0]  rseen, wseen, wcnt, rcnt, lvl, lvl_next;
  logic [DATA_W-1:0] rd_data_d;
  logic              rd_data_oe_n_d;
  fifo_flags_t       flags_d;

  // storage; no reset so it maps onto block memory
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  always_ff @(posedge ref_clk) begin
    if (wr_go) begin
      mem[wbin_q[ADDR_W-1:0]] <= pins_q.wr_data;
    end
  end

  // each side sees the other's pointer only through its gray copy
  always_comb begin
    wbin_d   = wbin_q + {{(PTR_W-1){1'b0}}, wr_go};
    rbin_d   = rbin_q + {{(PTR_W-1){1'b0}}, rd_go};
    wgray_d  = bin2gray(wbin_d);
    rgray_d  = bin2gray(rbin_d);
    rseen    = gray2bin(rgray_q);
    wseen    = gray2bin(wgray_q);
    wcnt     = wbin_d - rseen;               // level seen by the writer
    rcnt     = wseen - rbin_d;               // level seen by the reader
    lvl      = wseen - rseen;
    lvl_next = gray2bin(wgray_d) - gray2bin(rgray_d);
  end

  // flags: full only on write edges, empty only on read edges
  always_comb begin
    flags_d = flags;
    if (wr_ev) begin
      flags_d.full_flag = (wcnt != DEPTH);
    end
    if (rd_ev) begin
      flags_d.empty_flag = (rcnt != '0);
    end
    if (async_mode) begin
      // free-running compare, no skew relation to either clock
      flags_d.almost_empty_flag = {3'h0, lvl} > {1'b0, pins_q.ae_offset};
      flags_d.almost_full_flag  =
        ({3'h0, lvl} + {1'b0, pins_q.af_offset}) < {3'h0, DEPTH};
    end else begin
      if (rd_ev) begin
        flags_d.almost_empty_flag = {3'h0, rcnt} > {1'b0, pins_q.ae_offset};
      end
      if (wr_ev) begin
        flags_d.almost_full_flag =
          ({3'h0, wcnt} + {1'b0, pins_q.af_offset}) < {3'h0, DEPTH};
      end
    end
    if (wr_ev | rd_ev) begin
      flags_d.half_level_flag = (lvl_next <= HALF_DEPTH);
    end
  end

  // read data holds the last word read once empty
  always_comb begin
    rd_data_d      = rd_go ? mem[rbin_q[ADDR_W-1:0]] : rd_data;
    rd_data_oe_n_d = pins_q.out_en_n;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wbin_q       <= PTR_RST;
      wgray_q      <= PTR_RST;
      rbin_q       <= PTR_RST;
      rgray_q      <= PTR_RST;
      flags        <= FLAGS_RST;
      rd_data      <= DATA_RST;
      rd_data_oe_n <= OE_N_RST;
    end else begin
      wbin_q       <= wbin_d;
      wgray_q      <= wgray_d;
      rbin_q       <= rbin_d;
      rgray_q      <= rgray_d;
      flags        <= flags_d;
      rd_data      <= rd_data_d;
      rd_data_oe_n <= rd_data_oe_n_d;
    end
  end

  // checks
  property p_no_write_full;
    @(posedge ref_clk) disable iff (!rstn)
      (wbin_q != $past(wbin_q)) |-> $past(flags.full_flag) && $past(wr_ev);
  endproperty
  a_no_write_full: assert property (p_no_write_full) else $error("write while full");

  property p_no_read_empty;
    @(posedge ref_clk) disable iff (!rstn)
      (rbin_q != $past(rbin_q)) |-> $past(flags.empty_flag) && $past(rd_ev);
  endproperty
  a_no_read_empty: assert property (p_no_read_empty) else $error("read while empty");

  property p_read_advance;
    @(posedge ref_clk) disable iff (!rstn)
      rd_go |=> (rbin_q == $past(rbin_q) + 14'h0001) && (rd_data == $past(mem[rbin_q[12:0]]));
  endproperty
  a_read_advance: assert property (p_read_advance) else $error("first word not read");

  property p_full_on_write_edge;
    @(posedge ref_clk) disable iff (!rstn)
      $changed(flags.full_flag) |-> $past(wr_ev);
  endproperty
  a_full_on_write_edge: assert property (p_full_on_write_edge) else $error("full off edge");

  property p_empty_on_read_edge;
    @(posedge ref_clk) disable iff (!rstn)
      $changed(flags.empty_flag) |-> $past(rd_ev);
  endproperty
  a_empty_on_read_edge: assert property (p_empty_on_read_edge) else $error("empty off edge");

  property p_ae_sync;
    @(posedge ref_clk) disable iff (!rstn)
      ($changed(flags.almost_empty_flag) && !$past(async_mode)) |-> $past(rd_ev);
  endproperty
  a_ae_sync: assert property (p_ae_sync) else $error("almost-empty off read edge");

  property p_af_sync;
    @(posedge ref_clk) disable iff (!rstn)
      ($changed(flags.almost_full_flag) && !$past(async_mode)) |-> $past(wr_ev);
  endproperty
  a_af_sync: assert property (p_af_sync) else $error("almost-full off write edge");

  property p_af_async;
    @(posedge ref_clk) disable iff (!rstn)
      async_mode |=> flags.almost_full_flag ==
        (({3'h0, $past(lvl)} + {1'b0, $past(pins_q.af_offset)}) < {3'h0, DEPTH});
  endproperty
  a_af_async: assert property (p_af_async) else $error("almost-full threshold");

  property p_oe_follow;
    @(posedge ref_clk) disable iff (!rstn)
      $rose(pins_q.out_en_n) |=> rd_data_oe_n ##1 (rd_data_oe_n || $fell(pins_q.out_en_n));
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("output enable lost");

  property p_ae_async;
    @(posedge ref_clk) disable iff (!rstn)
      async_mode |=> flags.almost_empty_flag ==
        ({3'h0, $past(lvl)} > {1'b0, $past(pins_q.ae_offset)});
  endproperty
  a_ae_async: assert property (p_ae_async) else $error("almost-empty threshold");

  // half flag against the pointers themselves, one cycle after an event
  property p_half_level;
    @(posedge ref_clk) disable iff (!rstn)
      $past(wr_ev || rd_ev) |-> flags.half_level_flag == ((wbin_q - rbin_q) <= HALF_DEPTH);
  endproperty
  a_half_level: assert property (p_half_level) else $error("half level wrong");

  c_full:    cover property (@(posedge ref_clk) disable iff (!rstn) $fell(flags.full_flag));
  c_leave_e: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(flags.empty_flag));
  c_ae_low:  cover property (@(posedge ref_clk) disable iff (!rstn) $fell(flags.almost_empty_flag));
  c_af_low:  cover property (@(posedge ref_clk) disable iff (!rstn) $fell(flags.almost_full_flag));
  c_half:    cover property (@(posedge ref_clk) disable iff (!rstn) $fell(flags.half_level_flag));
endmodule : fifo_flag_core
`default_nettype wire

// >>> verilog/fifo_flag_pkg.sv
package fifo_flag_pkg;
  localparam int unsigned DATA_W = 18;
  localparam int unsigned ADDR_W = 13;            // 8192-word storage
  localparam int unsigned PTR_W  = ADDR_W + 1;    // extra wrap bit
  localparam int unsigned OFF_W  = 16;            // offset width
  localparam int unsigned CMP_W  = OFF_W + 1;     // room for level plus offset
  localparam logic [PTR_W-1:0] DEPTH      = 14'h2000;
  localparam logic [PTR_W-1:0] HALF_DEPTH = 14'h1000;
  localparam logic [PTR_W-1:0] PTR_RST    = 14'h0000;
  localparam logic [DATA_W-1:0] DATA_RST  = 18'h00000;
  // flag polarity: every flag is low when its condition holds
  localparam logic FULL_RST  = 1'b1;
  localparam logic EMPTY_RST = 1'b0;
  localparam logic AE_RST    = 1'b0;
  localparam logic AF_RST    = 1'b1;
  localparam logic HALF_RST  = 1'b1;
  localparam logic OE_N_RST  = 1'b1;

  typedef struct packed {
    logic full_flag;
    logic empty_flag;
    logic almost_empty_flag;
    logic almost_full_flag;
    logic half_level_flag;
  } fifo_flags_t;

  typedef struct packed {
    logic              wr_clk;
    logic              rd_clk;
    logic              wr_en_n;
    logic              rd_en_n;
    logic              out_en_n;
    logic              flag_sync_select;
    logic [OFF_W-1:0]  ae_offset;
    logic [OFF_W-1:0]  af_offset;
    logic [DATA_W-1:0] wr_data;
  } fifo_pins_t;

  localparam fifo_flags_t FLAGS_RST = '{FULL_RST, EMPTY_RST, AE_RST, AF_RST, HALF_RST};
  // pins park at their idle levels: clocks low, enables and output off
  localparam fifo_pins_t PINS_RST = '{1'b0, 1'b0, 1'b1, 1'b1, OE_N_RST, 1'b0,
                                      16'h0000, 16'h0000, DATA_RST};

  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = '0;
    for (int i = PTR_W - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == PTR_W - 1) ? 1'b0 : b[i+1]);
    end
    gray2bin = b;
  endfunction : gray2bin
endpackage : fifo_flag_pkg
